// ### logic/dmb_exec.sv
// Execution unit for data moves, shifts, bit transfers and flag operations.
`timescale 1ns/1ps
`include "dmb_regs.svh"

module dmb_exec #(
  parameter logic [15:0] SP_INIT = 16'h0000
) (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  insValid,
  output logic                       insReady,
  input  wire dmb_pkg::dmb_ins_t     ins,
  output logic                       insDone,
  output dmb_pkg::dmb_mem_req_t      memReq,
  input  wire logic [7:0]            memRdata,
  output dmb_pkg::dmb_io_req_t       ioReq,
  output logic      [5:0]            ioPeekAddr,
  input  wire logic [7:0]            ioRdata,
  output logic      [15:0]           pmAddr,
  output logic                       pmRe,
  input  wire logic [7:0]            pmRdata,
  input  wire logic [5:0]            regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [7:0]            regRdata,
  output logic      [7:0]            flags
);

  // ========================================================================
  // State.
  typedef enum logic [3:0] {
    PH_IDLE  = 4'b0001,
    PH_MEM   = 4'b0010,
    PH_PMREQ = 4'b0100,
    PH_PMCAP = 4'b1000
  } dmb_state_t;

  dmb_state_t            state_q, state_d;
  dmb_pkg::dmb_ins_t     cur_q, cur_d;
  logic [7:0]            gpr_q [32];
  logic [7:0]            gpr_d [32];
  logic [7:0]            flagReg_q, flagReg_d;
  logic [15:0]           sp_q, sp_d;
  dmb_pkg::dmb_mem_req_t memReq_q, memReq_d;
  dmb_pkg::dmb_io_req_t  ioReq_q, ioReq_d;
  logic [15:0]           pmAddr_q, pmAddr_d;
  logic                  pmRe_q, pmRe_d;
  logic [7:0]            regRdata_q, regRdata_d;
  dmb_pkg::dmb_shift_t   shKind;
  logic [7:0]            shOut;
  logic                  shC;
  logic                  shZ;
  logic                  shN;
  logic                  shV;
  logic [4:0]            ptrLo;
  logic [15:0]           ptrVal;
  logic                  singleOp;

  // ========================================================================
  // Shifter.
  always_comb begin
    case (ins.op)
      dmb_pkg::OP_ROTL: shKind = dmb_pkg::SH_ROTL;
      dmb_pkg::OP_ROTR: shKind = dmb_pkg::SH_ROTR;
      dmb_pkg::OP_SHL:  shKind = dmb_pkg::SH_SHL;
      dmb_pkg::OP_SHR:  shKind = dmb_pkg::SH_SHR;
      default:          shKind = dmb_pkg::SH_SHRA;
    endcase
  end

  dmb_shift_unit u_shift (
    .kind (shKind),
    .din  (gpr_q[ins.rd]),
    .cin  (flagReg_q[`DMB_FLAG_C]),
    .dout (shOut),
    .cout (shC),
    .zOut (shZ),
    .nOut (shN),
    .vOut (shV)
  );

  // ========================================================================
  // Pointer selection and handshake.
  always_comb begin
    case (ins.ptr)
      dmb_pkg::PTR_Y: ptrLo = `DMB_PTR_Y_LO;
      dmb_pkg::PTR_Z: ptrLo = `DMB_PTR_Z_LO;
      default:        ptrLo = `DMB_PTR_X_LO;
    endcase
    ptrVal = {gpr_q[ptrLo + 5'd1], gpr_q[ptrLo]};
  end

  always_comb begin
    case (ins.op)
      dmb_pkg::OP_LOADP, dmb_pkg::OP_LOADD, dmb_pkg::OP_STOREP, dmb_pkg::OP_STORED,
      dmb_pkg::OP_PUSH, dmb_pkg::OP_POP, dmb_pkg::OP_IOSET, dmb_pkg::OP_IOCLR,
      dmb_pkg::OP_PMFETCH: singleOp = 1'b0;
      default:             singleOp = 1'b1;
    endcase
  end

  assign insReady   = (state_q == PH_IDLE);
  assign insDone    = (state_q == PH_IDLE && insValid && singleOp) || (state_q == PH_MEM)
                      || (state_q == PH_PMCAP);
  assign ioPeekAddr = ins.imm[5:0];
  assign memReq     = memReq_q;
  assign ioReq      = ioReq_q;
  assign pmAddr     = pmAddr_q;
  assign pmRe       = pmRe_q;
  assign regRdata   = regRdata_q;
  assign flags      = flagReg_q;

  // ========================================================================
  // Next-state logic.
  always_comb begin
    logic [15:0] ea;
    logic [15:0] ptrNew;
    ea          = ptrVal;
    ptrNew      = ptrVal;
    state_d     = state_q;
    cur_d       = cur_q;
    gpr_d       = gpr_q;
    flagReg_d   = flagReg_q;
    sp_d        = sp_q;
    memReq_d    = memReq_q;
    memReq_d.re = 1'b0;
    memReq_d.we = 1'b0;
    ioReq_d     = ioReq_q;
    ioReq_d.we  = 1'b0;
    pmAddr_d    = pmAddr_q;
    pmRe_d      = 1'b0;
    regRdata_d  = 8'h00;

    // Register port; instruction results below take precedence.
    if (regRd) begin
      if (regAddr <= `DMB_OFF_GPR_LAST) begin
        regRdata_d = gpr_q[regAddr[4:0]];
      end else if (regAddr == `DMB_OFF_FLAGS) begin
        regRdata_d = flagReg_q;
      end else if (regAddr == `DMB_OFF_SP_LO) begin
        regRdata_d = sp_q[7:0];
      end else if (regAddr == `DMB_OFF_SP_HI) begin
        regRdata_d = sp_q[15:8];
      end else if (regAddr == `DMB_OFF_STATE) begin
        regRdata_d = {4'h0, state_q};
      end
    end
    if (regWr) begin
      if (regAddr <= `DMB_OFF_GPR_LAST) begin
        gpr_d[regAddr[4:0]] = regWdata;
      end else if (regAddr == `DMB_OFF_FLAGS) begin
        flagReg_d = regWdata;
      end else if (regAddr == `DMB_OFF_SP_LO) begin
        sp_d[7:0] = regWdata;
      end else if (regAddr == `DMB_OFF_SP_HI) begin
        sp_d[15:8] = regWdata;
      end
    end

    case (state_q)
      PH_IDLE: begin
        if (insValid) begin
          cur_d = ins;
          // Effective address and pointer update for pointer modes.
          case (ins.mode)
            dmb_pkg::AM_POSTINC: ptrNew = ptrVal + 16'h0001;
            dmb_pkg::AM_PREDEC: begin
              ptrNew = ptrVal - 16'h0001;
              ea     = ptrNew;
            end
            dmb_pkg::AM_DISP: begin
              if (ins.ptr != dmb_pkg::PTR_X) begin
                ea = ptrVal + {10'h000, ins.imm[5:0]};
              end
            end
            default: ea = ptrVal;
          endcase
          case (ins.op)
            dmb_pkg::OP_COPY: gpr_d[ins.rd] = gpr_q[ins.rr];
            dmb_pkg::OP_LOADIMM: gpr_d[ins.rd] = ins.imm;
            dmb_pkg::OP_IN:   gpr_d[ins.rd] = ioRdata;
            dmb_pkg::OP_OUT: begin
              ioReq_d = '{addr: ins.imm[5:0], wdata: gpr_q[ins.rr], wmask: 8'hFF,
                          we: 1'b1};
            end
            dmb_pkg::OP_LOADP, dmb_pkg::OP_STOREP: begin
              memReq_d.addr  = ea;
              memReq_d.wdata = gpr_q[ins.rr];
              memReq_d.re    = (ins.op == dmb_pkg::OP_LOADP);
              memReq_d.we    = (ins.op == dmb_pkg::OP_STOREP);
              if (ins.mode == dmb_pkg::AM_POSTINC || ins.mode == dmb_pkg::AM_PREDEC) begin
                gpr_d[ptrLo]         = ptrNew[7:0];
                gpr_d[ptrLo + 5'd1]  = ptrNew[15:8];
              end
              state_d = PH_MEM;
            end
            dmb_pkg::OP_LOADD, dmb_pkg::OP_STORED: begin
              memReq_d.addr  = ins.addr;
              memReq_d.wdata = gpr_q[ins.rr];
              memReq_d.re    = (ins.op == dmb_pkg::OP_LOADD);
              memReq_d.we    = (ins.op == dmb_pkg::OP_STORED);
              state_d        = PH_MEM;
            end
            dmb_pkg::OP_PUSH: begin
              memReq_d.addr  = sp_q;
              memReq_d.wdata = gpr_q[ins.rr];
              memReq_d.we    = 1'b1;
              sp_d           = sp_q - 16'h0001;
              state_d        = PH_MEM;
            end
            dmb_pkg::OP_POP: begin
              memReq_d.addr = sp_q + 16'h0001;
              memReq_d.re   = 1'b1;
              sp_d          = sp_q + 16'h0001;
              state_d       = PH_MEM;
            end
            dmb_pkg::OP_IOSET, dmb_pkg::OP_IOCLR: begin
              ioReq_d.addr  = ins.imm[5:0];
              ioReq_d.wmask = 8'h01 << ins.bitSel;
              ioReq_d.wdata = (ins.op == dmb_pkg::OP_IOSET) ? 8'hFF : 8'h00;
              ioReq_d.we    = 1'b1;
              state_d       = PH_MEM;
            end
            dmb_pkg::OP_ROTL, dmb_pkg::OP_ROTR, dmb_pkg::OP_SHL, dmb_pkg::OP_SHR,
            dmb_pkg::OP_SHRA: begin
              gpr_d[ins.rd]          = shOut;
              flagReg_d[`DMB_FLAG_Z] = shZ;
              flagReg_d[`DMB_FLAG_C] = shC;
              flagReg_d[`DMB_FLAG_N] = shN;
              flagReg_d[`DMB_FLAG_V] = shV;
            end
            dmb_pkg::OP_SWAP: begin
              gpr_d[ins.rd] = {gpr_q[ins.rd][3:0], gpr_q[ins.rd][7:4]};
            end
            dmb_pkg::OP_TSTORE: begin
              flagReg_d[`DMB_FLAG_T] = gpr_q[ins.rr][ins.bitSel];
            end
            dmb_pkg::OP_TLOAD: begin
              gpr_d[ins.rd][ins.bitSel] = flagReg_q[`DMB_FLAG_T];
            end
            dmb_pkg::OP_FLAGON:  flagReg_d[ins.imm[2:0]] = 1'b1;
            dmb_pkg::OP_FLAGOFF: flagReg_d[ins.imm[2:0]] = 1'b0;
            dmb_pkg::OP_PMFETCH: begin
              pmAddr_d = {gpr_q[`DMB_PTR_Z_LO + 5'd1], gpr_q[`DMB_PTR_Z_LO]};
              pmRe_d   = 1'b1;
              state_d  = PH_PMREQ;
            end
            default: begin
            end
          endcase
        end
      end
      PH_MEM: begin
        if (cur_q.op == dmb_pkg::OP_LOADP || cur_q.op == dmb_pkg::OP_LOADD
            || cur_q.op == dmb_pkg::OP_POP) begin
          gpr_d[cur_q.rd] = memRdata;
        end
        state_d = PH_IDLE;
      end
      PH_PMREQ: state_d = PH_PMCAP;
      PH_PMCAP: begin
        gpr_d[0] = pmRdata;
        state_d  = PH_IDLE;
      end
      default: state_d = PH_IDLE;
    endcase
  end

  // ========================================================================
  // Registers.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= PH_IDLE;
      cur_q      <= '0;
      flagReg_q  <= `DMB_FLAGS_RESET;
      sp_q       <= SP_INIT;
      memReq_q   <= '0;
      ioReq_q    <= '0;
      pmAddr_q   <= 16'h0000;
      pmRe_q     <= 1'b0;
      regRdata_q <= 8'h00;
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= `DMB_GPR_RESET;
      end
    end else begin
      state_q    <= state_d;
      cur_q      <= cur_d;
      flagReg_q  <= flagReg_d;
      sp_q       <= sp_d;
      memReq_q   <= memReq_d;
      ioReq_q    <= ioReq_d;
      pmAddr_q   <= pmAddr_d;
      pmRe_q     <= pmRe_d;
      regRdata_q <= regRdata_d;
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= gpr_d[i];
      end
    end
  end

endmodule : dmb_exec

// ### logic/dmb_regs.svh
// Offsets, field positions, reset values and cycle counts of the move and bit-op unit.
`ifndef DMB_REGS_SVH
`define DMB_REGS_SVH

// ==========================================================================
// Status flag bit positions.
`define DMB_FLAG_C 3'd0
`define DMB_FLAG_Z 3'd1
`define DMB_FLAG_N 3'd2
`define DMB_FLAG_V 3'd3
`define DMB_FLAG_S 3'd4
`define DMB_FLAG_H 3'd5
`define DMB_FLAG_T 3'd6
`define DMB_FLAG_I 3'd7

// ==========================================================================
// Register port offsets; 0x00 to 0x1F are the working registers.
`define DMB_OFF_GPR_LAST 6'h1F
`define DMB_OFF_FLAGS    6'h20
`define DMB_OFF_SP_LO    6'h21
`define DMB_OFF_SP_HI    6'h22
`define DMB_OFF_STATE    6'h23

// ==========================================================================
// Reset values.
`define DMB_FLAGS_RESET 8'h00
`define DMB_GPR_RESET   8'h00

// ==========================================================================
// Pointer register pairs, low byte index.
`define DMB_PTR_X_LO 5'd26
`define DMB_PTR_Y_LO 5'd28
`define DMB_PTR_Z_LO 5'd30

// ==========================================================================
// Cycle counts.
`define DMB_CYC_SINGLE 2'd1
`define DMB_CYC_MEM    2'd2
`define DMB_CYC_PMEM   2'd3

`endif

// ### logic/dmb_pkg.sv
// Types shared by the move and bit-op execution unit.
package dmb_pkg;

  // ========================================================================
  // Operations.
  typedef enum logic [4:0] {
    OP_NOP       = 5'h00,
    OP_COPY      = 5'h01,
    OP_LOADIMM   = 5'h02,
    OP_LOADP     = 5'h03,
    OP_LOADD     = 5'h04,
    OP_STOREP    = 5'h05,
    OP_STORED    = 5'h06,
    OP_PUSH      = 5'h07,
    OP_POP       = 5'h08,
    OP_PMFETCH   = 5'h09,
    OP_IN        = 5'h0A,
    OP_OUT       = 5'h0B,
    OP_IOSET     = 5'h0C,
    OP_IOCLR     = 5'h0D,
    OP_ROTL      = 5'h0E,
    OP_ROTR      = 5'h0F,
    OP_SHL       = 5'h10,
    OP_SHR       = 5'h11,
    OP_SHRA      = 5'h12,
    OP_SWAP      = 5'h13,
    OP_TSTORE    = 5'h14,
    OP_TLOAD     = 5'h15,
    OP_FLAGON    = 5'h16,
    OP_FLAGOFF   = 5'h17
  } dmb_op_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } dmb_ptr_t;

  typedef enum logic [1:0] {
    AM_PLAIN   = 2'h0,
    AM_POSTINC = 2'h1,
    AM_PREDEC  = 2'h2,
    AM_DISP    = 2'h3
  } dmb_mode_t;

  typedef enum logic [2:0] {
    SH_ROTL = 3'h0,
    SH_ROTR = 3'h1,
    SH_SHL  = 3'h2,
    SH_SHR  = 3'h3,
    SH_SHRA = 3'h4
  } dmb_shift_t;

  // ========================================================================
  // Decoded instruction.
  typedef struct packed {
    dmb_op_t     op;
    logic [4:0]  rd;
    logic [4:0]  rr;
    dmb_ptr_t    ptr;
    dmb_mode_t   mode;
    logic [7:0]  imm;
    logic [2:0]  bitSel;
    logic [15:0] addr;
  } dmb_ins_t;

  // ========================================================================
  // Data memory and I/O requests.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        re;
    logic        we;
  } dmb_mem_req_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic       we;
  } dmb_io_req_t;

endpackage : dmb_pkg

// ### logic/dmb_shift_unit.sv
// Shift and rotate datapath with its flag results.
`timescale 1ns/1ps
module dmb_shift_unit (
  input  wire dmb_pkg::dmb_shift_t kind,
  input  wire logic [7:0]          din,
  input  wire logic                cin,
  output logic      [7:0]          dout,
  output logic                     cout,
  output logic                     zOut,
  output logic                     nOut,
  output logic                     vOut
);

  // ========================================================================
  // Datapath.
  always_comb begin
    case (kind)
      dmb_pkg::SH_ROTL: begin
        dout = {din[6:0], cin};
        cout = din[7];
      end
      dmb_pkg::SH_ROTR: begin
        dout = {cin, din[7:1]};
        cout = din[0];
      end
      dmb_pkg::SH_SHL: begin
        dout = {din[6:0], 1'b0};
        cout = din[7];
      end
      dmb_pkg::SH_SHR: begin
        dout = {1'b0, din[7:1]};
        cout = din[0];
      end
      dmb_pkg::SH_SHRA: begin
        dout = {din[7], din[7:1]};
        cout = din[0];
      end
      default: begin
        dout = din;
        cout = cin;
      end
    endcase
    zOut = (dout == 8'h00);
    nOut = dout[7];
    vOut = dout[7] ^ cout;
  end

endmodule : dmb_shift_unit

// ### sim/dmb_exec_monitor.sv
// Checker of the move and bit-op unit's port behaviour.
`timescale 1ns/1ps
module dmb_exec_monitor (
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic                  insValid,
  input wire logic                  insReady,
  input wire dmb_pkg::dmb_ins_t     ins,
  input wire logic                  insDone,
  input wire dmb_pkg::dmb_mem_req_t memReq,
  input wire logic [7:0]            memRdata,
  input wire dmb_pkg::dmb_io_req_t  ioReq,
  input wire logic [5:0]            ioPeekAddr,
  input wire logic [7:0]            ioRdata,
  input wire logic [15:0]           pmAddr,
  input wire logic                  pmRe,
  input wire logic [7:0]            pmRdata,
  input wire logic [5:0]            regAddr,
  input wire logic [7:0]            regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [7:0]            regRdata,
  input wire logic [7:0]            flags
);
  // ==========================================================================
  // Accept decode.
  logic             acc;
  logic             twoCyc;
  dmb_pkg::dmb_op_t op;
  assign acc    = insValid && insReady;
  assign op     = ins.op;
  assign twoCyc = op inside {dmb_pkg::OP_LOADP, dmb_pkg::OP_LOADD, dmb_pkg::OP_STOREP,
                  dmb_pkg::OP_STORED, dmb_pkg::OP_PUSH, dmb_pkg::OP_POP,
                  dmb_pkg::OP_IOSET, dmb_pkg::OP_IOCLR};
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Timing and effects.
  AST_MEM_TWO: assert property (
    acc && twoCyc |-> !insDone ##1 (insDone && !insReady))
    else $error("Memory operation did not finish in two cycles.");
  AST_ONE: assert property (
    acc && !twoCyc && op != dmb_pkg::OP_PMFETCH |-> insDone ##1 insReady)
    else $error("Single-cycle operation took longer.");
  AST_PM: assert property (
    acc && op == dmb_pkg::OP_PMFETCH |=> (pmRe && !insDone) ##1 (insDone && !pmRe))
    else $error("Program fetch timing wrong.");
  AST_LOAD: assert property (
    acc && op == dmb_pkg::OP_LOADP |=> memReq.re && !memReq.we && $stable(flags))
    else $error("Pointer load request wrong.");
  AST_STORE: assert property (
    acc && op inside {dmb_pkg::OP_STOREP, dmb_pkg::OP_STORED, dmb_pkg::OP_PUSH}
    |=> memReq.we && !memReq.re && $stable(flags))
    else $error("Store request wrong.");
  AST_IO: assert property (
    acc && op inside {dmb_pkg::OP_IOSET, dmb_pkg::OP_IOCLR} |=> ioReq.we
    && ioReq.wmask == (8'h01 << $past(ins.bitSel))
    && ioReq.wdata == (($past(op) == dmb_pkg::OP_IOSET) ? 8'hFF : 8'h00))
    else $error("I/O bit request wrong.");
  AST_FLAG_ON: assert property (
    acc && op == dmb_pkg::OP_FLAGON |=> flags == ($past(flags) | (8'h01 << $past(ins.imm[2:0]))))
    else $error("Flag set touched the wrong bit.");
  AST_TSTORE: assert property (
    acc && op == dmb_pkg::OP_TSTORE |=> ((flags ^ $past(flags)) & 8'hBF) == 8'h00)
    else $error("Bit store changed a flag other than T.");
endmodule : dmb_exec_monitor

bind dmb_exec dmb_exec_monitor dmb_exec_monitor_inst (.mclk, .nrst, .insValid, .insReady,
  .ins, .insDone, .memReq, .memRdata, .ioReq, .ioPeekAddr, .ioRdata, .pmAddr, .pmRe,
  .pmRdata, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .flags);

// ### sim/dmb_mem_model.sv
// Data memory, I/O space and program memory facing the unit.
`timescale 1ns/1ps
module dmb_mem_model (
  input  wire logic                  mclk,
  input  wire dmb_pkg::dmb_mem_req_t memReq,
  output logic      [7:0]            memRdata,
  input  wire dmb_pkg::dmb_io_req_t  ioReq,
  input  wire logic [5:0]            ioPeekAddr,
  output logic      [7:0]            ioRdata,
  input  wire logic [15:0]           pmAddr,
  input  wire logic                  pmRe,
  output logic      [7:0]            pmRdata
);
  logic [7:0] mem [256];
  logic [7:0] io [64];
  logic [7:0] noise_q = 8'h5A;
  logic [7:0] pm_q = 8'h00;
  logic       pmHit_q = 1'b0;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
    for (int i = 0; i < 64; i++) io[i] = 8'h5A;
  end
  // Read lines that are not answering toggle every cycle.
  always @(posedge mclk) begin
    noise_q <= ~noise_q;
    pmHit_q <= pmRe;
    pm_q    <= ~pmAddr[7:0];
    if (memReq.we) mem[memReq.addr[7:0]] <= memReq.wdata;
    if (ioReq.we) io[ioReq.addr] <= (io[ioReq.addr] & ~ioReq.wmask) | (ioReq.wdata & ioReq.wmask);
  end
  assign memRdata = memReq.re ? mem[memReq.addr[7:0]] : noise_q;
  assign ioRdata  = io[ioPeekAddr];
  assign pmRdata  = pmHit_q ? pm_q : noise_q;
endmodule : dmb_mem_model

// ### sim/tb_dmb_exec.sv
// Self-checking bench of the move and bit-op unit.
`timescale 1ns/1ps
module tb_dmb_exec;
  logic                  mclk = 1'b0;
  logic                  nrst = 1'b0;
  logic                  insValid = 1'b0;
  logic                  insReady;
  dmb_pkg::dmb_ins_t     ins = '0;
  logic                  insDone;
  dmb_pkg::dmb_mem_req_t memReq;
  logic [7:0]            memRdata;
  dmb_pkg::dmb_io_req_t  ioReq;
  logic [5:0]            ioPeekAddr;
  logic [7:0]            ioRdata;
  logic [15:0]           pmAddr;
  logic                  pmRe;
  logic [7:0]            pmRdata;
  logic [5:0]            regAddr = 6'h00;
  logic [7:0]            regWdata = 8'h00;
  logic                  regWr = 1'b0;
  logic                  regRd = 1'b0;
  logic [7:0]            regRdata;
  logic [7:0]            flags;
  dmb_pkg::dmb_ptr_t     pt = dmb_pkg::PTR_X;
  dmb_pkg::dmb_mode_t    mo = dmb_pkg::AM_PLAIN;
  dmb_pkg::dmb_op_t      shOp [6] = '{dmb_pkg::OP_ROTL, dmb_pkg::OP_ROTR, dmb_pkg::OP_SHL,
                                      dmb_pkg::OP_SHR, dmb_pkg::OP_SHRA, dmb_pkg::OP_SWAP};
  logic [7:0]            shRes [6] = '{8'h03, 8'hC0, 8'h02, 8'h40, 8'hC0, 8'h18};
  logic [7:0]            shFl [6] = '{8'h09, 8'h05, 8'h09, 8'h09, 8'h05, 8'h01};
  int                    n_errors = 0;
  int                    checks = 0;
  int                    cycles = 0;

  dmb_exec dmb_exec_inst (.mclk, .nrst, .insValid, .insReady, .ins, .insDone, .memReq,
    .memRdata, .ioReq, .ioPeekAddr, .ioRdata, .pmAddr, .pmRe, .pmRdata, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .flags);
  dmb_mem_model dmb_mem_model_inst (.mclk, .memReq, .memRdata, .ioReq, .ioPeekAddr,
    .ioRdata, .pmAddr, .pmRe, .pmRdata);

  // ==========================================================================
  // Clock, timeout and access tasks.
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(regRdata, exp);
  endtask : rd
  // Source register and bit index both ride in the low bits of a.
  task automatic run(input dmb_pkg::dmb_op_t op, input logic [4:0] r, input logic [7:0] k,
                     input logic [15:0] a, input logic [7:0] cyc);
    logic [7:0] n;
    n = 8'h01;
    @(posedge mclk);
    ins <= '{op: op, rd: r, rr: a[4:0], ptr: pt, mode: mo, imm: k, bitSel: a[2:0], addr: a};
    insValid <= 1'b1;
    @(negedge mclk);
    while (insDone !== 1'b1 && n < 8'h09) begin
      @(posedge mclk);
      insValid <= 1'b0;
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    insValid <= 1'b0;
    @(negedge mclk);
    chk(n, cyc);
  endtask : run

  // ==========================================================================
  // Test sequence.
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    wr(6'h1A, 8'h10);
    mo = dmb_pkg::AM_POSTINC;
    run(dmb_pkg::OP_LOADP, 5'h01, 8'h00, 16'h0000, 8'h02);
    rd(6'h01, 8'hD3);
    rd(6'h1A, 8'h11);
    mo = dmb_pkg::AM_PREDEC;
    run(dmb_pkg::OP_LOADP, 5'h02, 8'h00, 16'h0000, 8'h02);
    rd(6'h02, 8'hD3);
    rd(6'h1A, 8'h10);
    mo = dmb_pkg::AM_PLAIN;
    run(dmb_pkg::OP_LOADP, 5'h0D, 8'h00, 16'h0000, 8'h02);
    rd(6'h0D, 8'hD3);
    rd(6'h1A, 8'h10);
    wr(6'h1C, 8'h20);
    pt = dmb_pkg::PTR_Y;
    mo = dmb_pkg::AM_DISP;
    run(dmb_pkg::OP_LOADP, 5'h03, 8'h05, 16'h0000, 8'h02);
    rd(6'h03, 8'hE6);
    rd(6'h1C, 8'h20);
    run(dmb_pkg::OP_LOADD, 5'h04, 8'h00, 16'h0040, 8'h02);
    rd(6'h04, 8'h83);
    wr(6'h1E, 8'h30);
    wr(6'h05, 8'h77);
    pt = dmb_pkg::PTR_Z;
    mo = dmb_pkg::AM_POSTINC;
    run(dmb_pkg::OP_STOREP, 5'h00, 8'h00, 16'h0005, 8'h02);
    chk(dmb_mem_model_inst.mem[8'h30], 8'h77);
    rd(6'h1E, 8'h31);
    mo = dmb_pkg::AM_PREDEC;
    run(dmb_pkg::OP_STOREP, 5'h00, 8'h00, 16'h0004, 8'h02);
    chk(dmb_mem_model_inst.mem[8'h30], 8'h83);
    rd(6'h1E, 8'h30);
    pt = dmb_pkg::PTR_Y;
    mo = dmb_pkg::AM_DISP;
    run(dmb_pkg::OP_STOREP, 5'h00, 8'h03, 16'h0001, 8'h02);
    chk(dmb_mem_model_inst.mem[8'h23], 8'hD3);
    run(dmb_pkg::OP_STORED, 5'h00, 8'h00, 16'h0043, 8'h02);
    chk(dmb_mem_model_inst.mem[8'h43], 8'hE6);
    rd(6'h20, 8'h00);
    wr(6'h21, 8'h80);
    run(dmb_pkg::OP_PUSH, 5'h00, 8'h00, 16'h0005, 8'h02);
    chk(dmb_mem_model_inst.mem[8'h80], 8'h77);
    rd(6'h21, 8'h7F);
    run(dmb_pkg::OP_POP, 5'h06, 8'h00, 16'h0000, 8'h02);
    rd(6'h06, 8'h77);
    rd(6'h21, 8'h80);
    run(dmb_pkg::OP_IOSET, 5'h00, 8'h05, 16'h0000, 8'h02);
    chk(dmb_mem_model_inst.io[5], 8'h5B);
    run(dmb_pkg::OP_IOCLR, 5'h00, 8'h05, 16'h0006, 8'h02);
    chk(dmb_mem_model_inst.io[5], 8'h1B);
    foreach (shOp[j]) begin
      wr(6'h20, 8'h01);
      wr(6'h0C, 8'h81);
      run(shOp[j], 5'h0C, 8'h00, 16'h000C, 8'h01);
      rd(6'h0C, shRes[j]);
      rd(6'h20, shFl[j]);
    end
    run(dmb_pkg::OP_TSTORE, 5'h00, 8'h00, 16'h000C, 8'h01);
    rd(6'h20, 8'h41);
    run(dmb_pkg::OP_TLOAD, 5'h08, 8'h00, 16'h0002, 8'h01);
    rd(6'h08, 8'h04);
    wr(6'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      run(dmb_pkg::OP_FLAGON, 5'h00, 8'(i), 16'h0000, 8'h01);
      rd(6'h20, 8'h01 << i);
      run(dmb_pkg::OP_FLAGOFF, 5'h00, 8'(i), 16'h0000, 8'h01);
      rd(6'h20, 8'h00);
    end
    run(dmb_pkg::OP_COPY, 5'h09, 8'h00, 16'h0005, 8'h01);
    rd(6'h09, 8'h77);
    run(dmb_pkg::OP_LOADIMM, 5'h0A, 8'h3C, 16'h0000, 8'h01);
    rd(6'h0A, 8'h3C);
    run(dmb_pkg::OP_IN, 5'h0B, 8'h05, 16'h0000, 8'h01);
    rd(6'h0B, 8'h1B);
    run(dmb_pkg::OP_OUT, 5'h00, 8'h06, 16'h0005, 8'h01);
    run(dmb_pkg::OP_NOP, 5'h00, 8'h00, 16'h0000, 8'h01);
    chk(dmb_mem_model_inst.io[6], 8'h77);
    rd(6'h20, 8'h00);
    run(dmb_pkg::OP_PMFETCH, 5'h00, 8'h00, 16'h0000, 8'h03);
    rd(6'h00, 8'hCF);
    wrap_up();
  end
endmodule : tb_dmb_exec
